// file: sdp_pkg.sv
// shared constants and types for the dual-port ram and its port hosts
package sdp_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int NPORTS = 2;
    localparam int MEM_DEPTH = 2 ** ADDR_W;
    localparam logic [ADDR_W-1:0] MAILBOX_RIGHT = 19'h7ffff;
    localparam logic [ADDR_W-1:0] MAILBOX_LEFT = 19'h7fffe;
    localparam logic [ADDR_W-1:0] MASK_RESET = 19'h7ffff;
    localparam logic [ADDR_W-1:0] COUNTER_RESET = 19'h00000;
    localparam int CLK_PERIOD_PS = 5000;
    // master reset hold and recovery are counted in clock cycles
    localparam int MASTER_RESET_PULSE_CYC = 5;
    localparam int MASTER_RESET_RECOVERY_CYC = 5;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_INCR_READ = 3'h2,
        OP_INCR_WRITE = 3'h3,
        OP_CLEAR = 3'h4,
        OP_LOAD_MASK = 3'h5,
        OP_READBACK_CNT = 3'h6,
        OP_READBACK_MASK = 3'h7
    } sdp_op_t;

    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_RECOVER = 6'h02,
        ST_IDLE = 6'h04,
        ST_ISSUE = 6'h08,
        ST_WAIT = 6'h10,
        ST_TURN = 6'h20
    } sdp_hstate_t;
endpackage

// file: sdp_port_chk.sv
// concurrent checks on the left port pins of the dual-port ram
`timescale 1ns/1ps
module sdp_port_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chipEnableLowActive,
    input wire logic chipEnableHighActive,
    input wire logic readNotWrite,
    input wire logic outputEnable_n,
    input wire logic addressStrobe_n,
    input wire logic counterIncrement_n,
    input wire logic counterClear_n,
    input wire logic counterOrMaskSelect,
    input wire logic masterReset_n,
    input wire logic [sdp_pkg::ADDR_W-1:0] addrLine,
    input wire logic addrOe_n,
    input wire logic dataOe_n,
    input wire logic wrapInterrupt_n,
    input wire logic mailboxInterrupt_n,
    input wire logic lineConflict
);
    import sdp_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire enabled = !chipEnableLowActive && chipEnableHighActive;
    wire noCounterOp = counterClear_n && addressStrobe_n && counterIncrement_n;
    // every enabled cycle with no counter op and master reset high is a readback, whether it reads or writes
    wire readbackReq = enabled && noCounterOp && masterReset_n;
    wire incrReq = !counterIncrement_n && counterClear_n && addressStrobe_n && counterOrMaskSelect;
    wire mboxRead = enabled && readNotWrite && !addressStrobe_n && counterOrMaskSelect
        && counterClear_n && masterReset_n && addrLine == MAILBOX_LEFT;

    deselect_float_a: assert property (!enabled |=> dataOe_n)
        else $error("data driven after deselect");
    read_drive_a: assert property (enabled && readNotWrite && masterReset_n
        |=> outputEnable_n || !dataOe_n)
        else $error("read did not drive data next cycle");
    write_float_a: assert property (enabled && !readNotWrite |=> dataOe_n)
        else $error("data driven after write cycle");
    oe_async_a: assert property (outputEnable_n |-> dataOe_n)
        else $error("data driven with output enable high");
    readback_drive_a: assert property (readbackReq |=> !addrOe_n)
        else $error("readback did not drive address");
    addr_release_a: assert property (!readbackReq |=> addrOe_n)
        else $error("address driven without readback");
    reset_idle_a: assert property (!masterReset_n
        |=> dataOe_n && addrOe_n && wrapInterrupt_n && mailboxInterrupt_n)
        else $error("outputs or flags active after master reset");
    line_clash_a: assert property (!lineConflict)
        else $error("host and ram drive one bus");
    wrap_cause_a: assert property ($fell(wrapInterrupt_n) |-> $past(incrReq))
        else $error("wrap flag set without increment");
    wrap_hold_a: assert property (!wrapInterrupt_n && noCounterOp && masterReset_n
        |=> !wrapInterrupt_n)
        else $error("wrap flag dropped without counter op");
    mailbox_clear_a: assert property (mboxRead |=> mailboxInterrupt_n)
        else $error("mailbox flag not cleared by read");
    write_turn_a: assert property (enabled && !readNotWrite |-> outputEnable_n)
        else $error("write issued with output enable low");
    reset_recover_a: assert property ($rose(masterReset_n) |-> (!enabled) [*5])
        else $error("access during master reset recovery");
endmodule

// file: sdp_port_host.sv
// host controller for one ram port: turns commands into pin cycles
`timescale 1ns/1ps
module sdp_port_host (
    input wire logic clk_sys,
    input wire logic rst,
    sdp_port_if.host bus,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire sdp_pkg::sdp_op_t cmdOp,
    input wire logic [sdp_pkg::ADDR_W-1:0] cmdAddr,
    input wire logic [sdp_pkg::DATA_W-1:0] cmdData,
    input wire logic [sdp_pkg::LANES-1:0] cmdByteEnable,
    output logic rspValid,
    output logic [sdp_pkg::DATA_W-1:0] rspData,
    output logic [sdp_pkg::ADDR_W-1:0] rspAddr,
    output logic wrapIrq,
    output logic mailboxIrq
);
    import sdp_pkg::*;

    sdp_hstate_t st;
    sdp_hstate_t next_st;
    sdp_op_t opQ;
    logic [2:0] count;
    logic [ADDR_W-1:0] addrQ;
    logic [DATA_W-1:0] dataQ;
    logic [LANES-1:0] beQ;

    wire logic inIssue = (st == ST_ISSUE);
    wire logic isRead = (opQ == OP_READ) || (opQ == OP_INCR_READ);
    wire logic isWrite = (opQ == OP_WRITE) || (opQ == OP_INCR_WRITE);
    wire logic isRb = (opQ == OP_READBACK_CNT) || (opQ == OP_READBACK_MASK);
    wire logic isStrobe = (opQ == OP_READ) || (opQ == OP_WRITE) || (opQ == OP_LOAD_MASK);
    wire logic isInc = (opQ == OP_INCR_READ) || (opQ == OP_INCR_WRITE);
    wire logic releaseAddr = isRb && (inIssue || st == ST_WAIT || st == ST_TURN);

    assign bus.chipEnableLowActive = !(inIssue && (isRead || isWrite || isRb));
    assign bus.chipEnableHighActive = 1'b1;
    assign bus.readNotWrite = !(inIssue && isWrite);
    // output enable stays high on writes, so no turnaround no-op can spoil a word
    assign bus.outputEnable_n = !((inIssue || st == ST_WAIT) && isRead);
    assign bus.addressStrobe_n = !(inIssue && isStrobe);
    assign bus.counterIncrement_n = !(inIssue && isInc);
    assign bus.counterClear_n = !(inIssue && opQ == OP_CLEAR);
    assign bus.counterOrMaskSelect = !(opQ == OP_LOAD_MASK || opQ == OP_READBACK_MASK);
    assign bus.byteLaneEnable_n = inIssue ? ~beQ : '1;
    assign bus.addrToRam = addrQ;
    assign bus.hostAddrOe_n = releaseAddr;
    assign bus.dataToRam = dataQ;
    assign bus.hostDataOe_n = !(inIssue && isWrite);
    assign bus.masterReset_n = (st != ST_RESET);
    assign cmdReady = (st == ST_IDLE);

    always_comb begin
        next_st = st;
        unique case (st)
            ST_RESET: begin
                if (count == 3'(MASTER_RESET_PULSE_CYC - 1)) next_st = ST_RECOVER;
            end
            ST_RECOVER: begin
                if (count == 3'(MASTER_RESET_RECOVERY_CYC - 1)) next_st = ST_IDLE;
            end
            ST_IDLE: begin
                if (cmdValid) next_st = ST_ISSUE;
            end
            ST_ISSUE: next_st = (isRead || isRb) ? ST_WAIT : ST_IDLE;
            ST_WAIT: next_st = isRb ? ST_TURN : ST_IDLE;
            ST_TURN: next_st = ST_IDLE;
            default: next_st = ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= ST_RESET;
            count <= 3'h0;
            opQ <= OP_READ;
            addrQ <= '0;
            dataQ <= '0;
            beQ <= '0;
            rspValid <= 1'b0;
            rspData <= '0;
            rspAddr <= '0;
            wrapIrq <= 1'b0;
            mailboxIrq <= 1'b0;
        end else begin
            st <= next_st;
            count <= (next_st != st) ? 3'h0 : count + 3'h1;
            if (st == ST_IDLE && cmdValid) begin
                opQ <= cmdOp;
                addrQ <= cmdAddr;
                dataQ <= cmdData;
                beQ <= cmdByteEnable;
            end
            rspValid <= (st == ST_WAIT);
            if (st == ST_WAIT) begin
                rspData <= bus.dataLine;
                rspAddr <= bus.addrLine;
            end
            wrapIrq <= !bus.wrapInterrupt_n;
            mailboxIrq <= !bus.mailboxInterrupt_n;
        end
    end
endmodule

// file: sdp_port_if.sv
// pins of one ram port, with the shared address and data lines resolved
`timescale 1ns/1ps
interface sdp_port_if;
    import sdp_pkg::*;
    logic chipEnableLowActive;
    logic chipEnableHighActive;
    logic readNotWrite;
    logic outputEnable_n;
    logic addressStrobe_n;
    logic counterIncrement_n;
    logic counterClear_n;
    logic counterOrMaskSelect;
    logic masterReset_n;
    logic [LANES-1:0] byteLaneEnable_n;
    logic [ADDR_W-1:0] addrToRam;
    logic hostAddrOe_n;
    logic [ADDR_W-1:0] addrFromRam;
    logic addrOe_n;
    logic [DATA_W-1:0] dataToRam;
    logic hostDataOe_n;
    logic [DATA_W-1:0] dataFromRam;
    logic dataOe_n;
    logic wrapInterrupt_n;
    logic mailboxInterrupt_n;
    logic [ADDR_W-1:0] addrLine;
    logic [DATA_W-1:0] dataLine;
    logic lineConflict;

    // level seen on the shared lines; the ram wins if both drive
    assign addrLine = !addrOe_n ? addrFromRam : addrToRam;
    assign dataLine = !dataOe_n ? dataFromRam : dataToRam;
    assign lineConflict = (!addrOe_n && !hostAddrOe_n) || (!dataOe_n && !hostDataOe_n);

    modport ram (
        input chipEnableLowActive, chipEnableHighActive, readNotWrite, outputEnable_n,
        input addressStrobe_n, counterIncrement_n, counterClear_n, counterOrMaskSelect,
        input masterReset_n, byteLaneEnable_n, addrToRam, dataToRam,
        output addrFromRam, addrOe_n, dataFromRam, dataOe_n,
        output wrapInterrupt_n, mailboxInterrupt_n
    );
    modport host (
        output chipEnableLowActive, chipEnableHighActive, readNotWrite, outputEnable_n,
        output addressStrobe_n, counterIncrement_n, counterClear_n, counterOrMaskSelect,
        output masterReset_n, byteLaneEnable_n, addrToRam, hostAddrOe_n,
        output dataToRam, hostDataOe_n,
        input addrLine, dataLine, wrapInterrupt_n, mailboxInterrupt_n, lineConflict
    );
endinterface

// file: sdp_ram_device.sv
// dual-port ram core: two synchronous ports, burst counters, mailboxes
// What this block does
// - inputs sampled on clock; output enable asynchronous
// - strobe and increment low reload address each edge
// - deselect floats data after next edge
// - chip enable change acts after one cycle
// - output state follows previous cycle's controls
// - decode deselect, write, read, outputs disabled
// - first write with output enable low is no-op
// - host rewrites address after no-op cycle
// - counter clear costs no dead cycle
// - increment past wrap repeats loaded block
// - readback drives counter or mask on address
// - host releases address before readback drive
// - host drives address only after release
// - same-location collision needs clock skew met
// - collision read yields new data later
// - wrap interrupt always driven, low at max
// - left write to top address flags right
// - host asserts a byte enable on mailbox
// - mailbox set by writer, cleared by reader
// - host holds master reset, then recovers
// - master reset idles outputs, clears flags
`timescale 1ns/1ps
module sdp_ram_device (
    input wire logic clk_sys,
    input wire logic rst,
    sdp_port_if.ram portLeft,
    sdp_port_if.ram portRight
);
    import sdp_pkg::*;

    function automatic logic [ADDR_W-1:0] mailboxOf(input int port);
        return (port == 1) ? MAILBOX_RIGHT : MAILBOX_LEFT;
    endfunction

    logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

    wire [NPORTS-1:0] ceLow;
    wire [NPORTS-1:0] ceHigh;
    wire [NPORTS-1:0] rnw;
    wire [NPORTS-1:0] oeN;
    wire [NPORTS-1:0] strobeN;
    wire [NPORTS-1:0] incN;
    wire [NPORTS-1:0] clrN;
    wire [NPORTS-1:0] sel;
    wire [NPORTS-1:0] masterResetN;
    wire [LANES-1:0] beN [NPORTS];
    wire [ADDR_W-1:0] addrIn [NPORTS];
    wire [DATA_W-1:0] dataIn [NPORTS];

    wire [ADDR_W-1:0] effAddr [NPORTS];
    wire [NPORTS-1:0] doWrite;
    wire [LANES-1:0] laneWr [NPORTS];
    wire [ADDR_W-1:0] addrOut [NPORTS];
    wire [DATA_W-1:0] rdOut [NPORTS];
    wire [NPORTS-1:0] addrOeN;
    wire [NPORTS-1:0] dataOeN;
    wire [NPORTS-1:0] wrapOutN;
    wire [NPORTS-1:0] mbxOutN;

    // index 0 is the left port, index 1 the right port
    assign ceLow = {portRight.chipEnableLowActive, portLeft.chipEnableLowActive};
    assign ceHigh = {portRight.chipEnableHighActive, portLeft.chipEnableHighActive};
    assign rnw = {portRight.readNotWrite, portLeft.readNotWrite};
    assign oeN = {portRight.outputEnable_n, portLeft.outputEnable_n};
    assign strobeN = {portRight.addressStrobe_n, portLeft.addressStrobe_n};
    assign incN = {portRight.counterIncrement_n, portLeft.counterIncrement_n};
    assign clrN = {portRight.counterClear_n, portLeft.counterClear_n};
    assign sel = {portRight.counterOrMaskSelect, portLeft.counterOrMaskSelect};
    assign masterResetN = {portRight.masterReset_n, portLeft.masterReset_n};
    assign beN[0] = portLeft.byteLaneEnable_n;
    assign beN[1] = portRight.byteLaneEnable_n;
    assign addrIn[0] = portLeft.addrToRam;
    assign addrIn[1] = portRight.addrToRam;
    assign dataIn[0] = portLeft.dataToRam;
    assign dataIn[1] = portRight.dataToRam;

    // master reset is one global pin, so either host pulling it low resets both ports
    wire logic resetAll = rst || !(&masterResetN);

    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        localparam int OTHER = 1 - p;
        logic wasWrite;
        logic readQ;
        logic rbQ;
        logic wrapQ;
        logic mbxQ;
        logic [ADDR_W-1:0] counter;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] loaded;
        logic [ADDR_W-1:0] rbValue;
        logic [DATA_W-1:0] dataQ;

        wire logic en = !ceLow[p] && ceHigh[p];
        wire logic wrReq = en && !rnw[p];
        wire logic rdReq = en && rnw[p];
        // the bus still carries read data, so a write cannot land this cycle
        wire logic noop = wrReq && !wasWrite && !oeN[p];
        wire logic cntClear = sel[p] && !clrN[p];
        wire logic cntLoad = sel[p] && clrN[p] && !strobeN[p];
        wire logic cntInc = sel[p] && clrN[p] && strobeN[p] && !incN[p];
        wire logic mskClear = !sel[p] && !clrN[p];
        wire logic mskLoad = !sel[p] && clrN[p] && !strobeN[p];
        wire logic readback = en && clrN[p] && strobeN[p] && incN[p];
        wire logic atMax = (counter & mask) == mask;
        wire logic [ADDR_W-1:0] stepped = (counter & ~mask) | ((counter + ADDR_W'(1)) & mask);
        wire logic [ADDR_W-1:0] incAddr = atMax ? loaded : stepped;
        wire logic wrapHit = cntInc && !atMax && ((stepped & mask) == mask);
        wire logic mbxSet = doWrite[OTHER] && (|laneWr[OTHER])
            && (effAddr[OTHER] == mailboxOf(p));
        wire logic mbxClr = rdReq && (effAddr[p] == mailboxOf(p));

        // the access of this edge uses the address it just produced: no dead cycle
        assign effAddr[p] = cntClear ? COUNTER_RESET
            : cntLoad ? addrIn[p]
            : cntInc ? incAddr
            : counter;
        assign doWrite[p] = wrReq && !noop;
        assign laneWr[p] = doWrite[p] ? ~beN[p] : '0;

        // counter side: address, mask, retransmit origin and wrap flag
        always_ff @(posedge clk_sys) begin
            if (resetAll) begin
                counter <= COUNTER_RESET;
                mask <= MASK_RESET;
                loaded <= COUNTER_RESET;
                wrapQ <= 1'b0;
            end else begin
                counter <= effAddr[p];
                if (cntLoad) begin
                    loaded <= addrIn[p];
                end
                if (mskClear) begin
                    mask <= MASK_RESET;
                end else if (mskLoad) begin
                    mask <= addrIn[p];
                end
                if (wrapHit) begin
                    wrapQ <= 1'b1;
                end else if (cntClear || cntLoad || cntInc) begin
                    wrapQ <= 1'b0;
                end
            end
        end

        // access side: output state of the next cycle, read word, readback value
        always_ff @(posedge clk_sys) begin
            if (resetAll) begin
                rbValue <= COUNTER_RESET;
                dataQ <= '0;
                wasWrite <= 1'b0;
                readQ <= 1'b0;
                rbQ <= 1'b0;
            end else begin
                wasWrite <= wrReq;
                readQ <= rdReq;
                rbQ <= readback;
                if (readback) begin
                    rbValue <= sel[p] ? counter : mask;
                end
                // a collision reads the old word; the new one shows on the next read
                if (rdReq) begin
                    dataQ <= mem[effAddr[p]];
                end
            end
        end

        // a write and a read of the mailbox in one cycle leave the flag set
        always_ff @(posedge clk_sys) begin
            if (resetAll) begin
                mbxQ <= 1'b0;
            end else if (mbxSet) begin
                mbxQ <= 1'b1;
            end else if (mbxClr) begin
                mbxQ <= 1'b0;
            end
        end

        // output enable bypasses the clock, gating the registered read state
        assign dataOeN[p] = !(readQ && !oeN[p]);
        assign rdOut[p] = dataQ;
        assign addrOeN[p] = !rbQ;
        assign addrOut[p] = rbValue;
        assign wrapOutN[p] = !wrapQ;
        assign mbxOutN[p] = !mbxQ;
    end

    // both ports writing one word at once is undefined; the right port lands last
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < NPORTS; p++) begin
            for (int l = 0; l < LANES; l++) begin
                if (laneWr[p][l]) begin
                    mem[effAddr[p]][l*LANE_W +: LANE_W] <= dataIn[p][l*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign portLeft.addrFromRam = addrOut[0];
    assign portLeft.addrOe_n = addrOeN[0];
    assign portLeft.dataFromRam = rdOut[0];
    assign portLeft.dataOe_n = dataOeN[0];
    assign portLeft.wrapInterrupt_n = wrapOutN[0];
    assign portLeft.mailboxInterrupt_n = mbxOutN[0];
    assign portRight.addrFromRam = addrOut[1];
    assign portRight.addrOe_n = addrOeN[1];
    assign portRight.dataFromRam = rdOut[1];
    assign portRight.dataOe_n = dataOeN[1];
    assign portRight.wrapInterrupt_n = wrapOutN[1];
    assign portRight.mailboxInterrupt_n = mbxOutN[1];
endmodule

// file: sdp_ram_device_tb.sv
// self-checking bench: two port hosts driving the dual-port ram
`timescale 1ns/1ps
module sdp_ram_device_tb;
    import sdp_pkg::*;
    localparam logic [DATA_W-1:0] D1 = 36'h123456789;
    localparam logic [DATA_W-1:0] D2 = 36'hfedcba987;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmdValid [2];
    sdp_op_t cmdOp [2];
    logic [ADDR_W-1:0] cmdAddr [2];
    logic [DATA_W-1:0] cmdData [2];
    logic [LANES-1:0] cmdByteEnable [2];
    logic cmdReady [2];
    logic rspValid [2];
    logic [DATA_W-1:0] rspData [2];
    logic [ADDR_W-1:0] rspAddr [2];
    logic wrapIrq [2];
    logic mailboxIrq [2];
    logic [DATA_W-1:0] gotData;
    logic [ADDR_W-1:0] gotAddr;
    int nMismatch = 0;
    int checkCount = 0;

    always #2.5 clk_sys = ~clk_sys;
    sdp_port_if ports [2] ();
    sdp_ram_device i_sdp_ram_device (.clk_sys(clk_sys), .rst(rst),
        .portLeft(ports[0]), .portRight(ports[1]));
    for (genvar p = 0; p < 2; p++) begin : g_host
        sdp_port_host i_sdp_port_host (.clk_sys(clk_sys), .rst(rst), .bus(ports[p]),
            .cmdValid(cmdValid[p]), .cmdReady(cmdReady[p]), .cmdOp(cmdOp[p]),
            .cmdAddr(cmdAddr[p]), .cmdData(cmdData[p]), .cmdByteEnable(cmdByteEnable[p]),
            .rspValid(rspValid[p]), .rspData(rspData[p]), .rspAddr(rspAddr[p]),
            .wrapIrq(wrapIrq[p]), .mailboxIrq(mailboxIrq[p]));
    end
    sdp_port_chk i_sdp_port_chk (.clk_sys(clk_sys), .rst(rst),
        .chipEnableLowActive(ports[0].chipEnableLowActive),
        .chipEnableHighActive(ports[0].chipEnableHighActive),
        .readNotWrite(ports[0].readNotWrite), .outputEnable_n(ports[0].outputEnable_n),
        .addressStrobe_n(ports[0].addressStrobe_n),
        .counterIncrement_n(ports[0].counterIncrement_n),
        .counterClear_n(ports[0].counterClear_n),
        .counterOrMaskSelect(ports[0].counterOrMaskSelect),
        .masterReset_n(ports[0].masterReset_n), .addrLine(ports[0].addrLine),
        .addrOe_n(ports[0].addrOe_n), .dataOe_n(ports[0].dataOe_n),
        .wrapInterrupt_n(ports[0].wrapInterrupt_n),
        .mailboxInterrupt_n(ports[0].mailboxInterrupt_n),
        .lineConflict(ports[0].lineConflict));

    task automatic fail_now(input string msg);
        $display("MISMATCH at %0t: %s", $time, msg);
        nMismatch++;
    endtask
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checkCount++;
        if (got !== exp) fail_now($sformatf("data %h expected %h", got, exp));
    endtask
    task automatic check_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        checkCount++;
        if (got !== exp) fail_now($sformatf("address %h expected %h", got, exp));
    endtask
    task automatic check_flag(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) fail_now($sformatf("flag %b expected %b", got, exp));
    endtask
    task automatic do_cmd(input int p, input sdp_op_t op, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [LANES-1:0] be);
        int n;
        @(posedge clk_sys);
        cmdValid[p] <= 1'b1;
        cmdOp[p] <= op;
        cmdAddr[p] <= a;
        cmdData[p] <= d;
        cmdByteEnable[p] <= be;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (cmdReady[p] !== 1'b1 && n < 50);
        if (cmdReady[p] !== 1'b1) begin
            fail_now("command never taken");
            tallyAndFinish();
        end
        @(posedge clk_sys);
        cmdValid[p] <= 1'b0;
        if (op inside {OP_READ, OP_INCR_READ, OP_READBACK_CNT, OP_READBACK_MASK}) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (rspValid[p] !== 1'b1 && n < 20);
            if (rspValid[p] !== 1'b1) begin
                fail_now("no response");
                tallyAndFinish();
            end
            gotData = rspData[p];
            gotAddr = rspAddr[p];
        end
    endtask
    // flags are flopped in the host, so allow a few cycles of travel
    task automatic wait_flag(input int p, input bit mbox, input logic exp);
        logic got;
        got = ~exp;
        for (int n = 0; n < 10 && got !== exp; n++) begin
            @(negedge clk_sys);
            got = mbox ? mailboxIrq[p] : wrapIrq[p];
        end
        check_flag(got, exp);
    endtask

    initial begin
        for (int p = 0; p < 2; p++) begin
            cmdValid[p] = 1'b0;
            cmdOp[p] = OP_READ;
            cmdAddr[p] = '0;
            cmdData[p] = '0;
            cmdByteEnable[p] = 4'hf;
        end
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        do_cmd(0, OP_WRITE, 19'h00010, D1, 4'hf);
        do_cmd(1, OP_READ, 19'h00010, '0, 4'hf);
        check_data(gotData, D1);
        do_cmd(0, OP_WRITE, 19'h00010, D2, 4'h5);
        do_cmd(0, OP_READ, 19'h00010, '0, 4'hf);
        check_data(gotData, {D1[35:27], D2[26:18], D1[17:9], D2[8:0]});
        $display("test access done");
        do_cmd(0, OP_READBACK_MASK, '0, '0, 4'hf);
        check_addr(gotAddr, MASK_RESET);
        do_cmd(0, OP_READBACK_CNT, '0, '0, 4'hf);
        check_addr(gotAddr, 19'h00010);
        do_cmd(0, OP_CLEAR, '0, '0, 4'hf);
        do_cmd(0, OP_READBACK_CNT, '0, '0, 4'hf);
        check_addr(gotAddr, COUNTER_RESET);
        $display("test readback done");
        do_cmd(0, OP_WRITE, 19'h00020, D1, 4'hf);
        repeat (3) @(posedge clk_sys);
        fork
            do_cmd(0, OP_WRITE, 19'h00020, D2, 4'hf);
            do_cmd(1, OP_READ, 19'h00020, '0, 4'hf);
        join
        check_data(gotData, D1);
        do_cmd(1, OP_READ, 19'h00020, '0, 4'hf);
        check_data(gotData, D2);
        $display("test collision done");
        do_cmd(0, OP_WRITE, 19'h00042, D1, 4'hf);
        do_cmd(0, OP_WRITE, 19'h00043, D2, 4'hf);
        do_cmd(0, OP_LOAD_MASK, 19'h00003, '0, 4'hf);
        do_cmd(0, OP_READBACK_MASK, '0, '0, 4'hf);
        check_addr(gotAddr, 19'h00003);
        do_cmd(0, OP_READ, 19'h00042, '0, 4'hf);
        wait_flag(0, 1'b0, 1'b0);
        do_cmd(0, OP_INCR_READ, '0, '0, 4'hf);
        check_data(gotData, D2);
        wait_flag(0, 1'b0, 1'b1);
        do_cmd(0, OP_INCR_READ, '0, '0, 4'hf);
        check_data(gotData, D1);
        wait_flag(0, 1'b0, 1'b0);
        do_cmd(0, OP_LOAD_MASK, MASK_RESET, '0, 4'hf);
        $display("test wrap done");
        do_cmd(0, OP_WRITE, MAILBOX_RIGHT, D1, 4'h1);
        wait_flag(1, 1'b1, 1'b1);
        wait_flag(0, 1'b1, 1'b0);
        do_cmd(1, OP_READ, MAILBOX_RIGHT, '0, 4'hf);
        wait_flag(1, 1'b1, 1'b0);
        do_cmd(1, OP_WRITE, MAILBOX_LEFT, D2, 4'h8);
        wait_flag(0, 1'b1, 1'b1);
        do_cmd(0, OP_READ, MAILBOX_LEFT, '0, 4'hf);
        wait_flag(0, 1'b1, 1'b0);
        $display("test mailbox done");
        tallyAndFinish();
    end
endmodule
